// ===== design/tpc_scan_control.sv
// Operation
// [RQ1] result registers reset to zero and ignore host writes
// [RQ2] results right-justified, twelve bits low, top four bits read zero
// [RQ3] finished conversion writes only the register of its quantity
// [RQ4] control reads return live status for status-defined bits
// [RQ5] control bit 15 reads pen down, zero after reset
// [RQ6] control bit 15 write picks host or device as initiator
// [RQ7] control bit 14 reads zero when busy, one when idle
// [RQ8] writing bit 14 high aborts and powers down at once
// [RQ9] mode field resets to no scan; code 0001 repeats X then Y
// [RQ10] code 0010 repeats X, Y, Z1, Z2 until pen lifts or stop
// [RQ11] code 0011 converts X only, code 0100 converts Y only
// [RQ12] code 0101 converts both pressure measurements
// [RQ13] codes 0110, 0111, 1000 convert battery one, two, auxiliary once
// [RQ14] code 1001 repeats the auxiliary conversion
// [RQ15] codes 1010 and 1100 convert first and second temperature
// [RQ16] code 1011 converts battery one, battery two, auxiliary in turn
// [RQ17] code 1101 turns on X drivers without converting
// [RQ18] ready output goes low on touch, high after selected conversions
// [RQ19] codes 1110 and 1111 turn on other driver pairs, no conversion
// [RQ20] ended repeating scan returns to idle and shows not busy
`timescale 1ns/1ps
`default_nettype none

module tpc_scan_control (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_page_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input wire logic pen_touch_i,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    output logic conv_start_o,
    output logic [3:0] conv_chan_o,
    output logic conv_power_down_o,
    output logic [3:0] panel_drive_o,
    output logic pen_or_result_ready_output_n_o
);

    ////////////////////////////////////////////////////////////////////////
    // pen pin synchronisation
    logic pen_sync;
    logic pen_prev_q;
    logic pen_rise;
    tpc_sync3 u_pen_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pen_touch_i),
        .sync_o(pen_sync)
    );
    assign pen_rise = pen_sync & ~pen_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // scan tables: channel of each step and number of steps
    function automatic tpc_pkg::tpc_chan_t step_chan(
        input logic [3:0] mode,
        input logic [1:0] step
    );
        tpc_pkg::tpc_chan_t ch;
        ch = tpc_pkg::CH_X;
        case (mode)
            tpc_pkg::MODE_XY_SCAN, tpc_pkg::MODE_XYZ_SCAN: // [RQ9] [RQ10]
                ch = tpc_pkg::tpc_chan_t'({2'h0, step});
            tpc_pkg::MODE_X: ch = tpc_pkg::CH_X; // [RQ11]
            tpc_pkg::MODE_Y: ch = tpc_pkg::CH_Y; // [RQ11]
            tpc_pkg::MODE_Z: // [RQ12]
                ch = step[0] ? tpc_pkg::CH_Z2 : tpc_pkg::CH_Z1;
            tpc_pkg::MODE_BATTERY_ONE_INPUT: ch = tpc_pkg::CH_BATTERY_ONE_INPUT; // [RQ13]
            tpc_pkg::MODE_BATTERY_TWO_INPUT: ch = tpc_pkg::CH_BATTERY_TWO_INPUT; // [RQ13]
            tpc_pkg::MODE_AUX, tpc_pkg::MODE_AUX_SCAN:
                ch = tpc_pkg::CH_AUX; // [RQ13] [RQ14]
            tpc_pkg::MODE_THERMAL_FIRST_RESULT: ch = tpc_pkg::CH_THERMAL_FIRST_RESULT; // [RQ15]
            tpc_pkg::MODE_THERMAL_SECOND_RESULT: ch = tpc_pkg::CH_THERMAL_SECOND_RESULT; // [RQ15]
            tpc_pkg::MODE_PORT_SCAN: // [RQ16]
                ch = tpc_pkg::tpc_chan_t'(4'h4 + {2'h0, step});
            default: ch = tpc_pkg::CH_X;
        endcase
        return ch;
    endfunction

    // number of steps; zero steps means the mode converts nothing
    function automatic logic [2:0] step_count(input logic [3:0] mode);
        logic [2:0] n;
        n = 3'h0;
        case (mode)
            tpc_pkg::MODE_XY_SCAN, tpc_pkg::MODE_Z: n = 3'h2;
            tpc_pkg::MODE_XYZ_SCAN: n = 3'h4;
            tpc_pkg::MODE_PORT_SCAN: n = 3'h3;
            tpc_pkg::MODE_X, tpc_pkg::MODE_Y, tpc_pkg::MODE_BATTERY_ONE_INPUT,
            tpc_pkg::MODE_BATTERY_TWO_INPUT, tpc_pkg::MODE_AUX, tpc_pkg::MODE_AUX_SCAN,
            tpc_pkg::MODE_THERMAL_FIRST_RESULT, tpc_pkg::MODE_THERMAL_SECOND_RESULT: n = 3'h1;
            default: n = 3'h0; // [RQ9] [RQ17] [RQ19]
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control register and sequencer
    logic initiator_q;
    logic initiator_d;
    logic stop_q;
    logic stop_d;
    logic [3:0] mode_q;
    logic [3:0] mode_d;
    tpc_pkg::tpc_seq_t seq_q;
    tpc_pkg::tpc_seq_t seq_d;
    logic [1:0] step_q;
    logic [1:0] step_d;
    logic start_q;
    logic start_d;
    logic [3:0] chan_q;
    logic [3:0] chan_d;
    logic ready_n_q;
    logic ready_n_d;
    logic [3:0] drive_q;
    logic [3:0] drive_d;
    logic ctl_wr;
    logic [3:0] new_mode;
    logic [2:0] last;
    logic repeat_ok;
    logic store_en;

    assign ctl_wr = reg_wr_i && reg_page_i == tpc_pkg::PAGE_CTRL
        && reg_addr_i == tpc_pkg::ADDR_CONTROL;
    assign new_mode = reg_wdata_i[tpc_pkg::CTL_MODE_MSB:tpc_pkg::CTL_MODE_LSB];
    assign last = step_count(mode_q);
    // touch scans need the pen still down, auxiliary scan only a stop
    assign repeat_ok = (mode_q == tpc_pkg::MODE_AUX_SCAN)
        || ((mode_q == tpc_pkg::MODE_XY_SCAN
        || mode_q == tpc_pkg::MODE_XYZ_SCAN) && pen_sync);
    assign store_en = seq_q == tpc_pkg::SEQ_WAIT && conv_done_i;

    // next control and sequencer state; a control write overrides all but chan_d, and ready_n_d only when it stops
    always_comb
    begin
        initiator_d = initiator_q;
        stop_d = stop_q;
        mode_d = mode_q;
        seq_d = seq_q;
        step_d = step_q;
        start_d = 1'b0;
        chan_d = chan_q;
        ready_n_d = ready_n_q;
        if (pen_rise)
            ready_n_d = 1'b0; // [RQ18]
        case (seq_q)
            tpc_pkg::SEQ_IDLE:
            begin
                // device initiator restarts on each new touch
                if (initiator_q && pen_rise && !stop_q && last != 3'h0)
                begin
                    seq_d = tpc_pkg::SEQ_START; // [RQ6]
                    step_d = 2'h0;
                end
            end
            tpc_pkg::SEQ_START:
            begin
                start_d = 1'b1;
                chan_d = step_chan(mode_q, step_q);
                seq_d = tpc_pkg::SEQ_WAIT;
            end
            tpc_pkg::SEQ_WAIT:
            begin
                if (conv_done_i)
                begin
                    if ({1'b0, step_q} + 3'h1 < last)
                    begin
                        step_d = step_q + 2'h1;
                        seq_d = tpc_pkg::SEQ_START;
                    end
                    else if (repeat_ok)
                    begin
                        step_d = 2'h0; // [RQ9] [RQ10] [RQ14]
                        seq_d = tpc_pkg::SEQ_START;
                    end
                    else
                    begin
                        seq_d = tpc_pkg::SEQ_IDLE; // [RQ20]
                        ready_n_d = 1'b1; // [RQ18]
                    end
                end
                else if (!repeat_ok && (mode_q == tpc_pkg::MODE_XY_SCAN
                    || mode_q == tpc_pkg::MODE_XYZ_SCAN))
                begin
                    // pen lifted mid scan: drop the pending conversion
                    seq_d = tpc_pkg::SEQ_IDLE; // [RQ20]
                    ready_n_d = 1'b1;
                end
            end
            default: seq_d = tpc_pkg::SEQ_IDLE;
        endcase
        if (ctl_wr)
        begin
            initiator_d = reg_wdata_i[tpc_pkg::CTL_PEN_BIT]; // [RQ6]
            stop_d = reg_wdata_i[tpc_pkg::CTL_STOP_BIT];
            mode_d = new_mode;
            step_d = 2'h0;
            start_d = 1'b0;
            if (reg_wdata_i[tpc_pkg::CTL_STOP_BIT])
            begin
                seq_d = tpc_pkg::SEQ_IDLE; // [RQ8]
                ready_n_d = 1'b1;
            end
            else if (!reg_wdata_i[tpc_pkg::CTL_PEN_BIT]
                && step_count(new_mode) != 3'h0)
                seq_d = tpc_pkg::SEQ_START; // [RQ6]
            else
                seq_d = tpc_pkg::SEQ_IDLE;
        end
    end

    // driver pairs follow the driver-only mode codes
    always_comb
    begin
        drive_d = 4'h0;
        if (!stop_q)
        begin
            case (mode_q)
                tpc_pkg::MODE_DRV_X: // [RQ17]
                    drive_d = 4'(1 << tpc_pkg::DRV_XP | 1 << tpc_pkg::DRV_XN);
                tpc_pkg::MODE_DRV_Y: // [RQ19]
                    drive_d = 4'(1 << tpc_pkg::DRV_YP | 1 << tpc_pkg::DRV_YN);
                tpc_pkg::MODE_DRV_YX: // [RQ19]
                    drive_d = 4'(1 << tpc_pkg::DRV_YP | 1 << tpc_pkg::DRV_XN);
                default: drive_d = 4'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            initiator_q <= tpc_pkg::RST_INITIATOR;
            stop_q <= tpc_pkg::RST_STOP;
            mode_q <= tpc_pkg::RST_MODE; // [RQ9]
            seq_q <= tpc_pkg::SEQ_IDLE;
            step_q <= 2'h0;
            start_q <= 1'b0;
            chan_q <= 4'h0;
            ready_n_q <= 1'b1;
            drive_q <= 4'h0;
            pen_prev_q <= 1'b0;
        end
        else
        begin
            initiator_q <= initiator_d;
            stop_q <= stop_d;
            mode_q <= mode_d;
            seq_q <= seq_d;
            step_q <= step_d;
            start_q <= start_d;
            chan_q <= chan_d;
            ready_n_q <= ready_n_d;
            drive_q <= drive_d;
            pen_prev_q <= pen_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result registers, one per quantity
    logic [tpc_pkg::RES_BITS-1:0] res_q [tpc_pkg::NUM_RESULTS];
    genvar gi;
    generate
        for (gi = 0; gi < tpc_pkg::NUM_RESULTS; gi++)
        begin : g_res
            logic [tpc_pkg::RES_BITS-1:0] res_d;
            // host writes never reach here; only the converter loads it
            always_comb
            begin
                res_d = res_q[gi];
                if (store_en && chan_q == 4'(gi))
                    res_d = conv_data_i; // [RQ1] [RQ3]
            end
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                    res_q[gi] <= tpc_pkg::RES_RESET[11:0]; // [RQ1]
                else
                    res_q[gi] <= res_d;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read path; data comes one cycle after the read strobe
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    // unmapped words read zero
    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd_i)
        begin
            rdata_d = 16'h0000;
            if (reg_page_i == tpc_pkg::PAGE_CTRL
                && reg_addr_i == tpc_pkg::ADDR_CONTROL)
            begin
                rdata_d[tpc_pkg::CTL_PEN_BIT] = pen_sync; // [RQ4] [RQ5]
                rdata_d[tpc_pkg::CTL_STOP_BIT] =
                    (seq_q == tpc_pkg::SEQ_IDLE); // [RQ4] [RQ7]
                rdata_d[tpc_pkg::CTL_MODE_MSB:tpc_pkg::CTL_MODE_LSB] =
                    mode_q;
            end
            else if (reg_page_i == tpc_pkg::PAGE_DATA)
            begin
                for (int i = 0; i < tpc_pkg::NUM_RESULTS; i++)
                    if (reg_addr_i == tpc_pkg::RES_ADDR[i])
                        rdata_d = {4'h0, res_q[i]}; // [RQ2]
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            rdata_q <= 16'h0000;
        else
            rdata_q <= rdata_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign reg_rdata_o = rdata_q;
    assign conv_start_o = start_q;
    assign conv_chan_o = chan_q;
    assign conv_power_down_o = stop_q; // [RQ8]
    assign panel_drive_o = drive_q;
    assign pen_or_result_ready_output_n_o = ready_n_q;

endmodule

`default_nettype wire

// ===== design/tpc_pkg.sv
package tpc_pkg;

    // register pages and word addresses inside them
    localparam logic [3:0] PAGE_DATA = 4'h0;
    localparam logic [3:0] PAGE_CTRL = 4'h1;
    localparam logic [5:0] ADDR_CONTROL = 6'h00;
    localparam int NUM_RESULTS = 9;
    localparam int RES_BITS = 12;
    localparam int REG_BITS = 16;

    // converted quantities, also the converter channel code
    typedef enum logic [3:0] {
        CH_X = 4'h0,
        CH_Y = 4'h1,
        CH_Z1 = 4'h2,
        CH_Z2 = 4'h3,
        CH_BATTERY_ONE_INPUT = 4'h4,
        CH_BATTERY_TWO_INPUT = 4'h5,
        CH_AUX = 4'h6,
        CH_THERMAL_FIRST_RESULT = 4'h7,
        CH_THERMAL_SECOND_RESULT = 4'h8
    } tpc_chan_t;

    // data page word address of each result, indexed by channel code
    localparam logic [5:0] RES_ADDR [NUM_RESULTS] = '{
        6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h09, 6'h0a
    };
    localparam logic [REG_BITS-1:0] RES_RESET = 16'h0000;

    // control word field positions
    localparam int CTL_PEN_BIT = 15;
    localparam int CTL_STOP_BIT = 14;
    localparam int CTL_MODE_LSB = 10;
    localparam int CTL_MODE_MSB = 13;

    // reset values of the written control fields
    localparam logic RST_INITIATOR = 1'b0;
    localparam logic RST_STOP = 1'b0;
    localparam logic [3:0] RST_MODE = 4'h0;

    typedef enum logic [3:0] {
        MODE_NONE = 4'h0,
        MODE_XY_SCAN = 4'h1,
        MODE_XYZ_SCAN = 4'h2,
        MODE_X = 4'h3,
        MODE_Y = 4'h4,
        MODE_Z = 4'h5,
        MODE_BATTERY_ONE_INPUT = 4'h6,
        MODE_BATTERY_TWO_INPUT = 4'h7,
        MODE_AUX = 4'h8,
        MODE_AUX_SCAN = 4'h9,
        MODE_THERMAL_FIRST_RESULT = 4'ha,
        MODE_PORT_SCAN = 4'hb,
        MODE_THERMAL_SECOND_RESULT = 4'hc,
        MODE_DRV_X = 4'hd,
        MODE_DRV_Y = 4'he,
        MODE_DRV_YX = 4'hf
    } tpc_mode_t;

    // panel driver enable bit positions
    localparam int DRV_XP = 0;
    localparam int DRV_XN = 1;
    localparam int DRV_YP = 2;
    localparam int DRV_YN = 3;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_START = 2'b01,
        SEQ_WAIT = 2'b10
    } tpc_seq_t;

endpackage

// ===== design/tpc_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser; output moves once stages two and three agree
module tpc_sync3 (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);

    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic out_q;
    logic out_d;

    // first stage feeds only the second
    always_comb
    begin
        stage_d = {stage_q[1:0], async_i};
        out_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : out_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            stage_q <= 3'h0;
            out_q <= 1'b0;
        end
        else
        begin
            stage_q <= stage_d;
            out_q <= out_d;
        end
    end

    assign sync_o = out_q;

endmodule

`default_nettype wire

// ===== verification/tpc_scan_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_scan_control_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_page_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic conv_done_i,
    input wire logic conv_start_o,
    input wire logic [3:0] conv_chan_o,
    input wire logic conv_power_down_o,
    input wire logic [3:0] panel_drive_o,
    input wire logic pen_or_result_ready_output_n_o
);
    logic cw;
    logic cr;
    logic [3:0] wm;
    logic stp;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    // decoded control accesses
    assign cw = reg_wr_i && reg_page_i == 4'h1 && reg_addr_i == 6'h00;
    assign cr = reg_rd_i && reg_page_i == 4'h1 && reg_addr_i == 6'h00;
    assign wm = reg_wdata_i[13:10];
    assign stp = cw && reg_wdata_i[14];
    ////////////////////////////////////////////////////////////////////////
    a_stop_powers_down: assert property (stp |=> conv_power_down_o)
        else $error("stop write did not power down");
    a_stop_halts_starts: assert property (
        stp |=> !conv_start_o [*3])
        else $error("start seen after stop write");
    a_stop_then_idle: assert property (
        stp ##2 cr |=> reg_rdata_o[14])
        else $error("busy shown after stop");
    a_result_top_zero: assert property (
        reg_rd_i && reg_page_i == 4'h0 |=> reg_rdata_o[15:12] == 4'h0)
        else $error("result upper bits not zero");
    a_busy_read_low: assert property (
        cr && conv_start_o |=> !reg_rdata_o[14])
        else $error("idle shown during conversion");
    a_x_only_start: assert property (
        cw && reg_wdata_i == 16'h0c00 |-> ##2 conv_start_o
        && conv_chan_o == 4'h0)
        else $error("x conversion not started on x channel");
    a_driver_no_conv: assert property (
        cw && !reg_wdata_i[14] && (wm >= 4'hd || wm == 4'h0)
        |=> !conv_start_o [*3])
        else $error("driver or idle mode started a conversion");
    a_x_drivers_on: assert property (
        cw && !reg_wdata_i[14] && wm == 4'hd |-> ##2 panel_drive_o == 4'h3)
        else $error("x drivers not on");
    a_ready_after_stop: assert property (
        stp |-> ##[1:2] pen_or_result_ready_output_n_o)
        else $error("ready output not high after stop");
    c_stop: cover property (stp);
    c_done: cover property (conv_done_i);
    c_cross_drive: cover property (panel_drive_o == 4'h6);
endmodule
`default_nettype wire

// ===== verification/tpc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter with fixed latency; result is base xor channel pattern
module tpc_conv_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [3:0] chan_i,
    input wire logic pdn_i,
    input wire logic [7:0] lat_i,
    input wire logic [11:0] base_i,
    output logic done_o,
    output logic [11:0] data_o
);
    logic busy;
    logic [7:0] cnt;
    logic [3:0] ch;
    // data toggles outside done so a stale value can never match
    always @(posedge clk_i)
    begin
        #1;
        done_o = 1'b0;
        data_o = rst_n_i ? ~data_o : 12'h000;
        if (!rst_n_i || pdn_i)
            busy = 1'b0;
        else if (start_i)
        begin
            busy = 1'b1;
            cnt = lat_i;
            ch = chan_i;
        end
        else if (busy && cnt == 8'h00)
        begin
            busy = 1'b0;
            done_o = 1'b1;
            data_o = base_i ^ {3{ch}};
        end
        else if (busy)
            cnt = cnt - 8'h01;
    end
endmodule
`default_nettype wire

// ===== verification/tpc_scan_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_scan_control_test;
    logic clk_i;
    logic rst_n_i;
    logic [3:0] page;
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic pen;
    logic done;
    logic [11:0] cdata;
    logic start;
    logic [3:0] chan;
    logic pdn;
    logic [3:0] drive;
    logic rdy_n;
    logic [11:0] base;
    logic [15:0] q;
    logic [15:0] exp_r [9];
    logic [3:0] sm [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb,
        4'hc};
    logic [8:0] sk [9] = '{9'h001, 9'h002, 9'h00c, 9'h010, 9'h020, 9'h040,
        9'h080, 9'h070, 9'h100};
    logic [3:0] dm [4] = '{4'h0, 4'hd, 4'he, 4'hf};
    logic [3:0] de [4] = '{4'h0, 4'h3, 4'hc, 4'h6};
    int miscompares;
    int checks;
    int cyc;
    tpc_scan_control tpc_scan_control_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_page_i(page),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pen_touch_i(pen),
        .conv_done_i(done), .conv_data_i(cdata), .conv_start_o(start),
        .conv_chan_o(chan), .conv_power_down_o(pdn), .panel_drive_o(drive),
        .pen_or_result_ready_output_n_o(rdy_n));
    tpc_conv_model tpc_conv_model_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start), .chan_i(chan),
        .pdn_i(pdn), .lat_i(8'h06), .base_i(base), .done_o(done),
        .data_o(cdata));
    ////////////////////////////////////////////////////////////////////////
    // each access leaves one idle cycle so strobes never re-rise at once
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        page = (d === 16'hffff) ? 4'h0 : 4'h1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_i);
        #1;
        wr = 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] p, input logic [5:0] a);
        page = p;
        addr = a;
        rd = 1'b1;
        @(posedge clk_i);
        #1;
        rd = 1'b0;
        q = rdata;
        @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_res;
        for (int i = 0; i < 9; i++)
        begin
            rd_reg(4'h0, tpc_pkg::RES_ADDR[i]);
            chk("result", exp_r[i], q);
        end
    endtask
    task automatic set_exp(input logic [8:0] k, input logic [11:0] b);
        base = b;
        for (int i = 0; i < 9; i++)
            if (k[i])
                exp_r[i] = {4'h0, b ^ {3{i[3:0]}}};
    endtask
    // polls the idle bit with a bound, then checks it and the ready pin
    task automatic wait_idle;
        int k;
        k = 0;
        rd_reg(4'h1, 6'h00);
        while (q[14] !== 1'b1 && k < 200)
        begin
            rd_reg(4'h1, 6'h00);
            k++;
        end
        chk("idle", 16'h4000, q & 16'h4000);
        chk("ready", 16'h0001, {15'h0000, rdy_n});
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // a hang counts as a mismatch
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            miscompares++;
            give_verdict;
        end
    end
    initial
    begin
        {rst_n_i, page, addr, wr, rd, wdata, pen, base} = '0;
        {miscompares, checks, cyc} = '0;
        for (int i = 0; i < 9; i++)
            exp_r[i] = 16'h0000;
        pause(10);
        rst_n_i = 1'b1;
        chk_res;
        rd_reg(4'h1, 6'h00);
        chk("control", 16'h4000, q);
        rd_reg(4'h0, 6'h04);
        chk("unmapped", 16'h0000, q);
        wr_reg(6'h00, 16'hffff);
        rd_reg(4'h0, 6'h00);
        chk("x after write", 16'h0000, q);
        $display("test reset done");
        for (int i = 0; i < 9; i++)
        begin
            set_exp(sk[i], {i[3:0], 8'ha5});
            wr_reg(6'h00, {2'b00, sm[i], 10'h000});
            rd_reg(4'h1, 6'h00);
            chk("busy", 16'h0000, q & 16'h4000);
            wait_idle;
            chk_res;
        end
        $display("test single modes done");
        for (int j = 0; j < 2; j++)
        begin
            pen = 1'b1;
            pause(8);
            chk("ready low", 16'h0000, {15'h0000, rdy_n});
            rd_reg(4'h1, 6'h00);
            chk("pen", 16'h8000, q & 16'h8000);
            set_exp(j ? 9'h00f : 9'h003, 12'h6c3);
            wr_reg(6'h00, j ? 16'h0800 : 16'h0400);
            pause(60);
            set_exp(j ? 9'h00f : 9'h003, 12'h39e);
            pause(90);
            pen = 1'b0;
            pause(20);
            wait_idle;
            chk_res;
        end
        $display("test pen scans done");
        set_exp(9'h040, 12'h5a1);
        wr_reg(6'h00, 16'h2400);
        pause(30);
        set_exp(9'h040, 12'ha5e);
        pause(30);
        wr_reg(6'h00, 16'h4000);
        chk("power down", 16'h0001, {15'h0000, pdn});
        wait_idle;
        chk_res;
        $display("test aux scan and stop done");
        wr_reg(6'h00, 16'h8c00);
        pause(20);
        chk_res;
        set_exp(9'h001, 12'h2d7);
        pen = 1'b1;
        pause(30);
        wait_idle;
        chk_res;
        pen = 1'b0;
        pause(10);
        $display("test device start done");
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(6'h00, {2'b00, dm[i], 10'h000});
            pause(1);
            chk("drive", {12'h000, de[i]}, {12'h000, drive});
            wait_idle;
        end
        chk_res;
        $display("test drivers done");
        give_verdict;
    end
endmodule
bind tpc_scan_control tpc_scan_control_props tpc_scan_control_props_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_page_i(reg_page_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .conv_power_down_o(conv_power_down_o),
    .panel_drive_o(panel_drive_o),
    .pen_or_result_ready_output_n_o(pen_or_result_ready_output_n_o));
`default_nettype wire
